/* logic/cycling_preset_param_bank.sv */
// Per-preset parameter bank for preset cycling, with APB slave.
// Assumes the active cycling index, exposure events and trigger levels
// arrive synchronous to pclk; event inputs are one-cycle pulses.
// Preset and region selector registers are 1-based on the bus, as software numbers them; the line selector starts at 3.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module cycling_preset_param_bank (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [2:0]   active_preset,
    input  wire logic         exposure_mode_timed,
    input  wire logic [7:0]   region_count_vertical,
    input  wire logic         exposure_begin_event,
    input  wire logic         timer_one_done,
    input  wire logic         counter_one_done,
    input  wire logic         input_one_event,
    input  wire logic         input_two_event,
    input  wire logic         link_trigger_zero,
    input  wire logic         exposure_window_level,
    output logic      [15:0]  gain_value,
    output logic              gain_apply,
    output logic      [23:0]  exposure_time_value,
    output logic              exposure_time_apply,
    output logic      [23:0]  exposure_delay_value,
    output logic              exposure_delay_apply,
    output logic      [127:0] region_offsets,
    output logic              region_apply,
    output logic      [7:0]   feature_lock,
    output logic      [3:0]   line_out,
    output logic      [3:0]   line_oe
);

    typedef struct packed {
        // Software selectors and settings
        logic [2:0]             cfg_sel;
        logic [2:0]             region_sel;
        logic [1:0]             line_sel;
        logic [7:0]             part;
        logic [15:0]            pulse_w;

        // Stored presets
        logic [7:0][15:0]       gain;
        logic [7:0][23:0]       exp_time;
        logic [7:0][23:0]       exp_delay;
        logic [7:0][7:0][15:0]  offs;
        logic [7:0][3:0][3:0]   src;
        logic [7:0][3:0]        lvl;

        // Line pulse timers and trigger edge
        logic [3:0][15:0]       cnt;
        logic                   link_prev;

        // Bus answer
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;

        // Registered outputs
        logic [15:0]            gain_o;
        logic                   gain_en;
        logic [23:0]            time_o;
        logic                   time_en;
        logic [23:0]            delay_o;
        logic                   delay_en;
        logic [127:0]           offs_o;
        logic                   offs_en;
        logic [3:0]             line_o;
        logic [3:0]             line_e;
    } state_s;

    state_s q;
    state_s d;

    // Highest region number software may select, never above 8
    function automatic logic [3:0] region_limit(input logic [7:0] count);
        if (count == 8'h00) begin
            region_limit = 4'h1;
        end else if (count > 8'h08) begin
            region_limit = 4'h8;
        end else begin
            region_limit = count[3:0];
        end
    endfunction : region_limit

    // Preset and region selectors are numbered from 1 on the bus, from 0 inside
    function automatic logic [31:0] one_based(input logic [2:0] idx);
        one_based = {29'h0, idx} + 32'h0000_0001;
    endfunction : one_based

    function automatic logic [2:0] zero_based(input logic [31:0] num);
        zero_based = 3'(num - 32'h0000_0001);
    endfunction : zero_based

    // Refuses selector values outside lo..hi
    function automatic logic outside(input logic [31:0] v,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
        outside = v < lo || v > hi;
    endfunction : outside

    // One-cycle event that a pulse source reacts to
    function automatic logic src_event(input logic [3:0] src, input logic [5:0] ev);
        case (src)
            preset_bank_pkg::SRC_EXPOSURE_BEGIN:   src_event = ev[0];
            preset_bank_pkg::SRC_TIMER_ONE_DONE:   src_event = ev[1];
            preset_bank_pkg::SRC_COUNTER_ONE_DONE: src_event = ev[2];
            preset_bank_pkg::SRC_INPUT_ONE:        src_event = ev[3];
            preset_bank_pkg::SRC_INPUT_TWO:        src_event = ev[4];
            preset_bank_pkg::SRC_LINK_TRIGGER:     src_event = ev[5];
            default:                               src_event = 1'b0;
        endcase
    endfunction : src_event

    always_comb begin
        logic        setup;
        logic        commit;
        logic        bad;
        logic [31:0] rd;
        logic [5:0]  ev;
        logic [3:0]  ls;
        logic [2:0]  p;
        logic [2:0]  r;
        logic [1:0]  l;
        logic [2:0]  a;
        logic [3:0]  lim;
        d      = q;
        setup  = psel & ~penable;
        commit = psel & penable & q.pready & pwrite & ~q.pslverr;
        bad    = 1'b0;
        rd     = 32'h0000_0000;
        ev     = 6'h00;
        ls     = 4'h0;
        p      = q.cfg_sel;
        r      = q.region_sel;
        l      = q.line_sel;
        a      = active_preset;
        lim    = region_limit(region_count_vertical);

        // Zero wait state: answer in the first access cycle
        d.pready  = setup;
        d.pslverr = 1'b0;
        d.prdata  = 32'h0000_0000;

        if (setup) begin
            case (paddr)
                preset_bank_pkg::ADDR_PRESET_SEL: begin
                    rd  = one_based(p);
                    bad = pwrite && outside(pwdata, 32'h1, 32'(preset_bank_pkg::NUM_PRESETS));
                end
                preset_bank_pkg::ADDR_ACTIVE: begin
                    rd  = one_based(a);
                    bad = pwrite;
                end
                preset_bank_pkg::ADDR_GAIN: begin
                    rd = {16'h0, q.gain[p]};
                end
                preset_bank_pkg::ADDR_EXP_TIME: begin
                    rd = {8'h0, q.exp_time[p]};
                end
                preset_bank_pkg::ADDR_EXP_DELAY: begin
                    rd = {8'h0, q.exp_delay[p]};
                end
                preset_bank_pkg::ADDR_REGION_SEL: begin
                    rd  = one_based(r);
                    bad = pwrite && outside(pwdata, 32'h1, {28'h0, lim});
                end
                preset_bank_pkg::ADDR_REGION_OFFS: begin
                    rd = {16'h0, q.offs[p][r]};
                    // Lower region must stay below, so write regions bottom-up
                    bad = pwrite && (pwdata[31:16] != 16'h0 ||
                          (r != 3'h0 && pwdata[15:0] <= q.offs[p][r - 3'h1]));
                    // A region above that is already set caps the value too
                    if (r != 3'h7 && q.offs[p][r + 3'h1] != 16'h0 &&
                        pwdata[15:0] >= q.offs[p][r + 3'h1]) begin
                        bad = pwrite;
                    end
                end
                preset_bank_pkg::ADDR_LINE_SEL: begin
                    rd  = {30'h0, l} + preset_bank_pkg::FIRST_LINE_NUM;
                    bad = pwrite && outside(pwdata, preset_bank_pkg::FIRST_LINE_NUM,
                                            preset_bank_pkg::LAST_LINE_NUM);
                end
                preset_bank_pkg::ADDR_LINE_SRC: begin
                    rd  = {28'h0, q.src[p][l]};
                    bad = pwrite &&
                          pwdata > 32'(preset_bank_pkg::SRC_EXPOSURE_WINDOW);
                end
                preset_bank_pkg::ADDR_LINE_LEVEL: begin
                    rd = {31'h0, q.lvl[p][l]};
                end
                preset_bank_pkg::ADDR_PARTICIPATE: begin
                    rd = {24'h0, q.part};
                end
                preset_bank_pkg::ADDR_PULSE_WIDTH: begin
                    rd  = {16'h0, q.pulse_w};
                    bad = pwrite && pwdata[15:0] == 16'h0;
                end
                preset_bank_pkg::ADDR_STATUS: begin
                    rd  = {22'h0, exposure_mode_timed, exposure_window_level,
                           q.line_e, q.line_o};
                    bad = pwrite;
                end
                default: begin
                    bad = 1'b1;
                end
            endcase
            d.prdata  = bad ? 32'h0000_0000 : rd;
            d.pslverr = bad;
        end

        // Writes land only at the access edge that completes the transfer
        if (commit) begin
            case (paddr)
                preset_bank_pkg::ADDR_PRESET_SEL: begin
                    d.cfg_sel = zero_based(pwdata);
                end
                preset_bank_pkg::ADDR_GAIN: begin
                    d.gain[p] = pwdata[15:0];
                end
                preset_bank_pkg::ADDR_EXP_TIME: begin
                    d.exp_time[p] = pwdata[23:0];
                end
                preset_bank_pkg::ADDR_EXP_DELAY: begin
                    d.exp_delay[p] = pwdata[23:0];
                end
                preset_bank_pkg::ADDR_REGION_SEL: begin
                    d.region_sel = zero_based(pwdata);
                end
                preset_bank_pkg::ADDR_REGION_OFFS: begin
                    d.offs[p][r] = pwdata[15:0];
                end
                preset_bank_pkg::ADDR_LINE_SEL: begin
                    d.line_sel = 2'(pwdata - preset_bank_pkg::FIRST_LINE_NUM);
                end
                preset_bank_pkg::ADDR_LINE_SRC: begin
                    d.src[p][l] = pwdata[3:0];
                end
                preset_bank_pkg::ADDR_LINE_LEVEL: begin
                    d.lvl[p][l] = pwdata[0];
                end
                preset_bank_pkg::ADDR_PARTICIPATE: begin
                    d.part = pwdata[7:0];
                end
                preset_bank_pkg::ADDR_PULSE_WIDTH: begin
                    d.pulse_w = pwdata[15:0];
                end
                default: begin
                end
            endcase
        end

        // Shrinking the region count pulls the selector back into range
        if ({1'b0, d.region_sel} >= lim) begin
            d.region_sel = 3'(lim - 4'h1);
        end

        // Outputs follow the active preset only; other presets are inert
        d.gain_o   = q.gain[a];
        d.gain_en  = q.part[preset_bank_pkg::PART_GAIN];
        d.time_o   = q.exp_time[a];
        d.time_en  = q.part[preset_bank_pkg::PART_EXP_TIME] & exposure_mode_timed;
        d.delay_o  = q.exp_delay[a];
        d.delay_en = q.part[preset_bank_pkg::PART_EXP_DELAY];
        d.offs_o   = q.offs[a];
        d.offs_en  = q.part[preset_bank_pkg::PART_REGIONS];

        // Link trigger is a level; each rising edge counts once
        d.link_prev = link_trigger_zero;
        ev[0] = exposure_begin_event;
        ev[1] = timer_one_done;
        ev[2] = counter_one_done;
        ev[3] = input_one_event;
        ev[4] = input_two_event;
        ev[5] = link_trigger_zero & ~q.link_prev;

        for (int k = 0; k < preset_bank_pkg::NUM_LINES; k++) begin
            ls = q.src[a][k];
            // Retriggering restarts the pulse instead of stretching two
            if (src_event(ls, ev)) begin
                d.cnt[k] = q.pulse_w;
            end else if (q.cnt[k] != 16'h0) begin
                d.cnt[k] = q.cnt[k] - 16'h1;
            end
            case (ls)
                preset_bank_pkg::SRC_OFF: begin
                    d.line_o[k] = 1'b0;
                    d.line_e[k] = 1'b0;
                end
                preset_bank_pkg::SRC_SW_DRIVEN: begin
                    d.line_o[k] = q.lvl[a][k];
                    d.line_e[k] = 1'b1;
                end
                preset_bank_pkg::SRC_EXPOSURE_WINDOW: begin
                    d.line_o[k] = exposure_window_level;
                    d.line_e[k] = 1'b1;
                end
                default: begin
                    d.line_o[k] = d.cnt[k] != 16'h0;
                    d.line_e[k] = 1'b1;
                end
            endcase
            // A line outside the cycling is left to its standard control
            if (!q.part[preset_bank_pkg::PART_LINE0 + k]) begin
                d.line_o[k] = 1'b0;
                d.line_e[k] = 1'b0;
                // No stale pulse shows when the line rejoins the cycling
                d.cnt[k]    = 16'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q         <= '0;
            // Non-zero defaults: pulse length and gain
            q.pulse_w <= preset_bank_pkg::PULSE_W_RST;
            q.gain    <= {preset_bank_pkg::NUM_PRESETS{preset_bank_pkg::GAIN_RST}};
        end else begin
            q <= d;
        end
    end

    assign prdata               = q.prdata;
    assign pready               = q.pready;
    assign pslverr              = q.pslverr;
    assign gain_value           = q.gain_o;
    assign gain_apply           = q.gain_en;
    assign exposure_time_value  = q.time_o;
    assign exposure_time_apply  = q.time_en;
    assign exposure_delay_value = q.delay_o;
    assign exposure_delay_apply = q.delay_en;
    assign region_offsets       = q.offs_o;
    assign region_apply         = q.offs_en;
    assign feature_lock         = q.part;
    assign line_out             = q.line_o;
    assign line_oe              = q.line_e;

endmodule : cycling_preset_param_bank

`default_nettype wire

/* logic/preset_bank_pkg.sv */
// Package for the per-preset parameter bank: register map, field
// positions, reset values, output source codes and timing.
// Assumes a 20 MHz pclk and 32-bit APB with one register per word.
package preset_bank_pkg;

    localparam int unsigned NUM_PRESETS   = 8;
    localparam int unsigned NUM_REGIONS   = 8;
    localparam int unsigned NUM_LINES     = 4;
    localparam int unsigned CLK_PERIOD_NS = 50;

    // Register byte offsets
    localparam logic [7:0] ADDR_PRESET_SEL  = 8'h00;
    localparam logic [7:0] ADDR_ACTIVE      = 8'h04;
    localparam logic [7:0] ADDR_GAIN        = 8'h08;
    localparam logic [7:0] ADDR_EXP_TIME    = 8'h0c;
    localparam logic [7:0] ADDR_EXP_DELAY   = 8'h10;
    localparam logic [7:0] ADDR_REGION_SEL  = 8'h14;
    localparam logic [7:0] ADDR_REGION_OFFS = 8'h18;
    localparam logic [7:0] ADDR_LINE_SEL    = 8'h1c;
    localparam logic [7:0] ADDR_LINE_SRC    = 8'h20;
    localparam logic [7:0] ADDR_LINE_LEVEL  = 8'h24;
    localparam logic [7:0] ADDR_PARTICIPATE = 8'h28;
    localparam logic [7:0] ADDR_PULSE_WIDTH = 8'h2c;
    localparam logic [7:0] ADDR_STATUS      = 8'h30;

    // Participation bit positions
    localparam int unsigned PART_EXP_TIME  = 0;
    localparam int unsigned PART_EXP_DELAY = 1;
    localparam int unsigned PART_LINE0     = 2;
    localparam int unsigned PART_REGIONS   = 6;
    localparam int unsigned PART_GAIN      = 7;

    // Software-visible numbering of the output lines
    localparam logic [31:0] FIRST_LINE_NUM = 32'h0000_0003;
    localparam logic [31:0] LAST_LINE_NUM  = 32'h0000_0006;

    // Reset values: pulse length as time, then cycles derived from it, and gain
    localparam int unsigned PULSE_TIME_NS = 1000;
    localparam logic [15:0] PULSE_W_RST   = 16'(PULSE_TIME_NS / CLK_PERIOD_NS);
    localparam logic [15:0] GAIN_RST      = 16'h0100;

    typedef enum logic [3:0] {
        SRC_OFF,
        SRC_EXPOSURE_BEGIN,
        SRC_TIMER_ONE_DONE,
        SRC_COUNTER_ONE_DONE,
        SRC_INPUT_ONE,
        SRC_INPUT_TWO,
        SRC_SW_DRIVEN,
        SRC_LINK_TRIGGER,
        SRC_EXPOSURE_WINDOW
    } out_source_e;

endpackage : preset_bank_pkg

/* bench/line_receiver.sv */
// Model of the strobe and I/O devices hanging on the four output lines.
// Assumes line_out and line_oe are registered outputs in the pclk domain.
`timescale 1ns/1ps
`default_nettype none

module line_receiver (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] line_out,
    input  wire logic [3:0] line_oe,
    output logic      [3:0] closed,
    output logic      [7:0] pulses0
);
    logic prev_q;

    // Undriven line leaves the optocoupler open
    assign closed = line_out & line_oe;

    // Counts closures of the first line, one per strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q  <= 1'b0;
            pulses0 <= 8'h00;
        end else begin
            prev_q <= closed[0];
            if (closed[0] && !prev_q) begin
                pulses0 <= pulses0 + 8'h01;
            end
        end
    end
endmodule : line_receiver

`default_nettype wire

/* bench/preset_bank_monitor_monitor.sv */
// Concurrent checks on the ports of the preset parameter bank.
// Assumes one pclk domain and asynchronous active-low presetn.
`timescale 1ns/1ps
`default_nettype none

module preset_bank_monitor (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [2:0]  active_preset,
    input  wire logic        exposure_mode_timed,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [23:0] exposure_delay_value,
    input  wire logic        exposure_time_apply,
    input  wire logic [3:0]  line_out,
    input  wire logic [3:0]  line_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_idle_no_ready: assert property (!psel |=> !pready)
        else $error("ready without select");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error outside answer");
    a_read_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_off_line_low: assert property ((line_out & ~line_oe) == 4'h0)
        else $error("line active with driver off");
    a_time_needs_timed: assert property (!exposure_mode_timed |=> !exposure_time_apply)
        else $error("exposure time applied outside timed mode");
    // Only a write or a new active index may move the applied delay
    a_quiet_delay_hold: assert property (!(psel && penable && pwrite)
        && !$past(psel && penable && pwrite) && $stable(active_preset)
        |=> $stable(exposure_delay_value))
        else $error("delay changed without cause");
endmodule : preset_bank_monitor

bind cycling_preset_param_bank preset_bank_monitor mon_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .active_preset, .exposure_mode_timed,
    .prdata, .pready, .pslverr, .exposure_delay_value, .exposure_time_apply,
    .line_out, .line_oe
);

`default_nettype wire

/* bench/cycling_preset_param_bank_tb_top.sv */
// Self-checking bench for the preset parameter bank over APB.
// Assumes the bank package and a line_receiver model on the lines.
`timescale 1ns/1ps
`default_nettype none

module cycling_preset_param_bank_tb_top;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic [2:0]   active_preset = 3'h0;
    logic         timed = 1'b1;
    logic [7:0]   rc = 8'h08;
    logic [6:0]   ev = 7'h00;
    logic [31:0]  prdata;
    logic         pready, pslverr, gain_apply, eta, eda, ra;
    logic [15:0]  gain_value;
    logic [23:0]  etv, edv;
    logic [127:0] ro;
    logic [7:0]   fl, pulses;
    logic [3:0]   line_out, line_oe, closed;
    logic [15:0]  g [8];
    logic [23:0]  t [8];
    logic [23:0]  dl [8];
    int           err_count = 0;
    int           check_count = 0;

    always #25 pclk = ~pclk;

    cycling_preset_param_bank dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .active_preset(active_preset), .exposure_mode_timed(timed),
        .region_count_vertical(rc), .exposure_begin_event(ev[0]), .timer_one_done(ev[1]),
        .counter_one_done(ev[2]), .input_one_event(ev[3]), .input_two_event(ev[4]),
        .link_trigger_zero(ev[5]), .exposure_window_level(ev[6]), .gain_value(gain_value),
        .gain_apply(gain_apply), .exposure_time_value(etv), .exposure_time_apply(eta),
        .exposure_delay_value(edv), .exposure_delay_apply(eda), .region_offsets(ro),
        .region_apply(ra), .feature_lock(fl), .line_out(line_out), .line_oe(line_oe));

    line_receiver rx_u (.pclk(pclk), .presetn(presetn), .line_out(line_out),
        .line_oe(line_oe), .closed(closed), .pulses0(pulses));

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            err_count++;
            $display("wrong value %s exp %h got %h", n, x, s);
        end
    endtask : chk

    // Request held until pready is sampled, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee = 1'b0);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk("write error", 32'(e), 32'(ee));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee = 1'b0);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk("read error", 32'(e), 32'(ee));
        if (!ee) chk("read data", r, x);
    endtask : rd

    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
        @(negedge pclk);
    endtask : tick

    function automatic logic rsel_bad(input int v, input int c);
        int m;
        m = c < 1 ? 1 : (c > 8 ? 8 : c);
        return v < 1 || v > m;
    endfunction : rsel_bad

    function automatic int ev_idx(input int s);
        return s == 7 ? 5 : s - 1;
    endfunction : ev_idx

    initial begin
        repeat (30000) @(posedge pclk);
        err_count++;
        stop_test();
    end

    initial begin
        int v, n, h;
        void'($urandom(32'h96c13e74));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(preset_bank_pkg::ADDR_PRESET_SEL, 32'h1);
        rd(preset_bank_pkg::ADDR_GAIN, 32'h100);
        rd(preset_bank_pkg::ADDR_LINE_SEL, 32'h3);
        rd(preset_bank_pkg::ADDR_PULSE_WIDTH, 32'h14);
        rd(8'h34, 32'h0, 1'b1);
        wr(preset_bank_pkg::ADDR_ACTIVE, 32'h1, 1'b1);
        wr(preset_bank_pkg::ADDR_PRESET_SEL, 32'h9, 1'b1);
        wr(preset_bank_pkg::ADDR_PARTICIPATE, 32'hff);
        for (int p = 0; p < 8; p++) begin
            g[p] = 16'($urandom);
            t[p] = 24'($urandom);
            dl[p] = 24'($urandom);
            wr(preset_bank_pkg::ADDR_PRESET_SEL, 32'(p + 1));
            wr(preset_bank_pkg::ADDR_GAIN, 32'(g[p]));
            wr(preset_bank_pkg::ADDR_EXP_TIME, 32'(t[p]));
            wr(preset_bank_pkg::ADDR_EXP_DELAY, 32'(dl[p]));
        end
        for (int i = 0; i < 8; i++) begin
            v = $urandom_range(7, 0);
            @(posedge pclk);
            active_preset <= 3'(v);
            tick(3);
            chk("gain", 32'(gain_value), 32'(g[v]));
            chk("gain apply", 32'(gain_apply), 32'h1);
            chk("exposure time", 32'(etv), 32'(t[v]));
            chk("time apply", 32'(eta), 32'h1);
            chk("delay", 32'(edv), 32'(dl[v]));
            chk("delay apply", 32'(eda), 32'h1);
            chk("region apply", 32'(ra), 32'h1);
            chk("feature lock", 32'(fl), 32'hff);
            wr(preset_bank_pkg::ADDR_PRESET_SEL, 32'(v + 1));
            rd(preset_bank_pkg::ADDR_GAIN, 32'(g[v]));
        end
        @(posedge pclk);
        timed <= 1'b0;
        tick(3);
        chk("time apply", 32'(eta), 32'h0);
        @(posedge pclk);
        timed <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            @(posedge pclk);
            rc <= c ? 8'h0a : 8'h03;
            for (int s = 0; s < 10; s++)
                wr(preset_bank_pkg::ADDR_REGION_SEL, 32'(s), rsel_bad(s, c ? 10 : 3));
        end
        @(posedge pclk);
        rc <= 8'h02;
        tick(2);
        rd(preset_bank_pkg::ADDR_REGION_SEL, 32'h2);
        @(posedge pclk);
        active_preset <= 3'h0;
        wr(preset_bank_pkg::ADDR_PRESET_SEL, 32'h1);
        wr(preset_bank_pkg::ADDR_REGION_SEL, 32'h1);
        wr(preset_bank_pkg::ADDR_REGION_OFFS, 32'h64);
        wr(preset_bank_pkg::ADDR_REGION_OFFS, 32'h10000, 1'b1);
        wr(preset_bank_pkg::ADDR_REGION_SEL, 32'h2);
        wr(preset_bank_pkg::ADDR_REGION_OFFS, 32'h32, 1'b1);
        wr(preset_bank_pkg::ADDR_REGION_OFFS, 32'h12c);
        wr(preset_bank_pkg::ADDR_REGION_SEL, 32'h1);
        wr(preset_bank_pkg::ADDR_REGION_OFFS, 32'h12c, 1'b1);
        tick(3);
        chk("offsets", ro[31:0], {16'h012c, 16'h0064});
        for (int s = 0; s < 9; s++)
            wr(preset_bank_pkg::ADDR_LINE_SEL, 32'(s), s < 3 || s > 6);
        wr(preset_bank_pkg::ADDR_LINE_SEL, 32'h3);
        wr(preset_bank_pkg::ADDR_PULSE_WIDTH, 32'h0, 1'b1);
        wr(preset_bank_pkg::ADDR_PULSE_WIDTH, 32'h3);
        wr(preset_bank_pkg::ADDR_LINE_SRC, 32'h9, 1'b1);
        for (int s = 0; s < 9; s++) begin
            wr(preset_bank_pkg::ADDR_LINE_SRC, 32'(s));
            tick(2);
            chk("line enable", 32'(line_oe[0]), 32'(s != 0));
            if (s == 6) begin
                wr(preset_bank_pkg::ADDR_LINE_LEVEL, 32'h1);
                tick(3);
                chk("sw level", 32'(closed[0]), 32'h1);
                wr(preset_bank_pkg::ADDR_LINE_LEVEL, 32'h0);
                tick(3);
                chk("sw level", 32'(closed[0]), 32'h0);
            end else if (s == 8) begin
                @(posedge pclk);
                ev[6] <= 1'b1;
                tick(6);
                chk("window", 32'(line_out[0]), 32'h1);
                @(posedge pclk);
                ev[6] <= 1'b0;
                tick(3);
                chk("window", 32'(line_out[0]), 32'h0);
            end else if (s != 0) begin
                n = pulses;
                h = 0;
                @(posedge pclk);
                ev[ev_idx(s)] <= 1'b1;
                @(posedge pclk);
                ev[ev_idx(s)] <= 1'b0;
                repeat (8) @(negedge pclk) h += line_out[0];
                chk("pulse width", 32'(h), 32'h3);
                chk("pulse count", 32'(pulses), 32'(n + 1));
            end
        end
        wr(preset_bank_pkg::ADDR_PARTICIPATE, 32'h0);
        tick(2);
        chk("feature lock", 32'(fl), 32'h0);
        chk("delay apply", 32'(eda), 32'h0);
        chk("line enable", 32'(line_oe[0]), 32'h0);
        rd(preset_bank_pkg::ADDR_STATUS, 32'h200);
        stop_test();
    end
endmodule : cycling_preset_param_bank_tb_top

`default_nettype wire
